//--- hdl/cal_regs.sv
`timescale 1ns/100ps
module cal_regs
  import cal_regs_pkg::*;
#(
  parameter int CAL_TICKS = CAL_TICKS_DEFAULT   // ticks per calibration cycle
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // register port from the serial decoder
  input  wire logic [6:0]        i_addr,
  input  wire logic              i_wr_en,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_rd_en,
  output logic [15:0]            o_rdata,
  output logic                   o_rd_valid,
  // results from the analog calibration circuits
  input  wire logic [COMP_W-1:0] i_comp_result,
  input  wire logic              i_comp_of,
  input  wire logic              i_comp_uf,
  input  wire logic [RSET_W-1:0] i_rset_result,
  input  wire logic              i_rset_of,
  input  wire logic              i_rset_uf,
  input  wire logic [GAIN_W-1:0] i_gain_result,
  input  wire logic              i_gain_of,
  input  wire logic              i_gain_uf,
  // controls to the analog side
  output logic                   o_cal_clk_tick,
  output logic                   o_cal_busy,
  output logic                   o_gain_cal_en,
  output logic [RANGE_W-1:0]     o_offset_range,
  output logic                   o_rset_int_en,
  output logic [RSET_W-1:0]      o_rset_code,
  output logic [GAIN_W-1:0]      o_ch1_gain
);

  // elaboration check: a cycle needs at least one tick
  if (CAL_TICKS < 1 || CAL_TICKS > 255) begin : g_bad_ticks
    $error("CAL_TICKS out of range");
  end

  localparam logic [7:0] LAST_TICK = 8'(CAL_TICKS - 1);

  // ==========================================================
  // address decode
  logic wr_rset, wr_cfg, wr_comp, wr_upd, wr_gain;
  assign wr_rset = i_wr_en && (i_addr == OFS_CH1_RSET);
  assign wr_cfg  = i_wr_en && (i_addr == OFS_CAL_CONFIG);
  assign wr_comp = i_wr_en && (i_addr == OFS_COMP_OFS);
  assign wr_upd  = i_wr_en && (i_addr == OFS_UPDATE);
  assign wr_gain = i_wr_en && (i_addr == OFS_CH1_GAIN);

  // ==========================================================
  // staged settings, as written by the host
  logic                   stg_rset_en_q;     // internal resistor enable
  logic [RSET_W-1:0]      stg_rset_q;        // resistor code
  logic                   stg_gain_en_q;     // gain calibration enable
  logic [RANGE_W-1:0]     stg_range_q;       // offset range
  logic                   stg_clk_en_q;      // calibration clock enable
  logic [DIV_W-1:0]       stg_div_q;         // clock divider
  logic [GAIN_W-1:0]      stg_gain_q;        // channel gain

  // staging registers take writes at once
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stg_rset_en_q <= 1'b0;
      stg_rset_q    <= RSET_RESET;
      stg_gain_en_q <= 1'b0;
      stg_range_q   <= RANGE_RESET;
      stg_clk_en_q  <= 1'b0;
      stg_div_q     <= DIV_RESET;
      stg_gain_q    <= '0;
    end else begin
      if (wr_rset) begin
        stg_rset_en_q <= i_wdata[RSET_EN_BIT];
        stg_rset_q    <= i_wdata[RSET_LSB +: RSET_W];
      end
      if (wr_cfg) begin
        stg_gain_en_q <= i_wdata[CAL_MODE_EN_BIT];
        stg_range_q   <= i_wdata[RANGE_LSB +: RANGE_W];
        stg_clk_en_q  <= i_wdata[CLK_EN_BIT];
        stg_div_q     <= i_wdata[CLK_DIV_LSB +: DIV_W];
      end
      if (wr_gain) begin
        stg_gain_q <= i_wdata[GAIN_LSB +: GAIN_W];
      end
    end
  end

  // ==========================================================
  // update strobe: one pulse copies staged into active
  logic upd_q;  // reads back high for the cycle after the write

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      upd_q <= 1'b0;
    end else begin
      // self clearing: stays high only while an update write with bit 0 set is held, re-applying each cycle
      upd_q <= wr_upd && i_wdata[UPDATE_BIT];
    end
  end

  // active settings: these are what the hardware uses
  logic               act_rset_en_q;
  logic [RSET_W-1:0]  act_rset_q;
  logic               act_clk_en_q;
  logic [DIV_W-1:0]   act_div_q;
  logic [GAIN_W-1:0]  act_gain_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_rset_en_q  <= 1'b0;
      act_rset_q     <= RSET_RESET;
      o_gain_cal_en  <= 1'b0;
      o_offset_range <= RANGE_RESET;
      act_clk_en_q   <= 1'b0;
      act_div_q      <= DIV_RESET;
      act_gain_q     <= '0;
    end else if (upd_q) begin
      act_rset_en_q  <= stg_rset_en_q;
      act_rset_q     <= stg_rset_q;
      o_gain_cal_en  <= stg_gain_en_q;
      o_offset_range <= stg_range_q;
      act_clk_en_q   <= stg_clk_en_q;
      act_div_q      <= stg_div_q;
      act_gain_q     <= stg_gain_q;
    end
  end

  // ==========================================================
  // calibration clock divider: tick every div+1 cycles
  logic [DIV_W-1:0] div_cnt_q;
  logic             tick;
  assign tick = act_clk_en_q && (div_cnt_q == act_div_q);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_q      <= '0;
      o_cal_clk_tick <= 1'b0;
    end else begin
      // gated off: counter parks so the next enable starts clean
      if (!act_clk_en_q || tick) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
      o_cal_clk_tick <= tick;
    end
  end

  // ==========================================================
  // clear pulse: results drop on the falling edge of bit 8
  logic cal_reset_q;
  logic clear_res;
  assign clear_res = cal_reset_q && wr_cfg && !i_wdata[CAL_RESET_BIT];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_reset_q <= 1'b0;
    end else if (wr_cfg) begin
      cal_reset_q <= i_wdata[CAL_RESET_BIT];
    end
  end

  // ==========================================================
  // calibration engine
  cal_state_t state_q;
  logic [7:0] tick_cnt_q;   // ticks spent in this cycle
  logic       start_q;      // start bit as read back
  logic       done_q;       // completion flag
  logic       finish;
  assign finish = (state_q == ST_RUN) && tick && (tick_cnt_q == LAST_TICK);

  // a start while running is ignored; it cannot restart a cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q    <= ST_IDLE;
      tick_cnt_q <= '0;
      start_q    <= 1'b0;
      done_q     <= 1'b0;
      o_cal_busy <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_comp && i_wdata[START_BIT]) begin
            state_q    <= ST_RUN;
            tick_cnt_q <= '0;
            start_q    <= 1'b1;
            done_q     <= 1'b0;
            o_cal_busy <= 1'b1;
          end else if (clear_res) begin
            done_q <= 1'b0;
          end
        end
        ST_RUN: begin
          if (finish) begin
            state_q    <= ST_IDLE;
            start_q    <= 1'b0;
            done_q     <= 1'b1;
            o_cal_busy <= 1'b0;
          end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          o_cal_busy <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // result store: captured at the end of a cycle
  logic [COMP_W-1:0] comp_res_q;
  logic [RSET_W-1:0] rset_res_q;
  logic [GAIN_W-1:0] gain_res_q;
  logic [5:0]        flags_q;   // comp of/uf, rset of/uf, gain of/uf

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      comp_res_q <= '0;
      rset_res_q <= '0;
      gain_res_q <= '0;
      flags_q    <= '0;
    end else if (finish) begin
      comp_res_q <= i_comp_result;
      rset_res_q <= i_rset_result;
      flags_q[5:2] <= {i_comp_of, i_comp_uf, i_rset_of, i_rset_uf};
      // gain results only move when the gain circuit was enabled
      if (o_gain_cal_en) begin
        gain_res_q   <= i_gain_result;
        flags_q[1:0] <= {i_gain_of, i_gain_uf};
      end
    end else if (clear_res) begin
      comp_res_q <= '0;
      rset_res_q <= '0;
      gain_res_q <= '0;
      flags_q    <= '0;
    end
  end

  // ==========================================================
  // analog controls
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rset_int_en <= 1'b0;
      o_rset_code   <= RSET_RESET;
      o_ch1_gain    <= '0;
    end else begin
      o_rset_int_en <= act_rset_en_q;
      o_rset_code   <= act_rset_q;
      // programmed gain only rules outside calibration
      o_ch1_gain <= (state_q == ST_RUN) ? gain_res_q : act_gain_q;
    end
  end

  // ==========================================================
  // read mux, one cycle latency; unmapped reads give zero
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    case (i_addr)
      OFS_CH1_RSET: begin
        rd_mux[RSET_EN_BIT]                = act_rset_en_q;
        rd_mux[RSET_CAL_LSB +: RSET_W]     = rset_res_q;
        rd_mux[RSET_LSB +: RSET_W]         = stg_rset_q;
      end
      OFS_CAL_CONFIG: begin
        rd_mux[COMP_OF_BIT:GCAL_UF_BIT]    = flags_q;
        rd_mux[CAL_RESET_BIT]              = cal_reset_q;
        rd_mux[CAL_MODE_BIT]               = o_cal_busy;
        rd_mux[CAL_MODE_EN_BIT]            = stg_gain_en_q;
        rd_mux[RANGE_LSB +: RANGE_W]       = stg_range_q;
        rd_mux[CLK_EN_BIT]                 = stg_clk_en_q;
        rd_mux[CLK_DIV_LSB +: DIV_W]       = stg_div_q;
      end
      OFS_COMP_OFS: begin
        rd_mux[COMP_CAL_LSB +: COMP_W]     = comp_res_q;
        rd_mux[CALIB_DONE_FLAG_BIT]                = done_q;
        rd_mux[START_BIT]                  = start_q;
      end
      OFS_UPDATE: begin
        rd_mux[UPDATE_BIT]                 = upd_q;
      end
      OFS_CH1_GAIN: begin
        rd_mux[GAIN_CAL_LSB +: GAIN_W]     = gain_res_q;
        rd_mux[GAIN_LSB +: GAIN_W]         = stg_gain_q;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata    <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // assertions
  sequence s_start_write;
    (state_q == ST_IDLE) && wr_comp && i_wdata[START_BIT];
  endsequence

  sequence s_running;
    o_cal_busy && !done_q;
  endsequence

  update_applies_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_upd && i_wdata[UPDATE_BIT] |=> upd_q ##1
      ((!upd_q || $past(wr_upd)) && act_rset_q == $past(stg_rset_q)))
    else $error("update strobe did not apply or clear");

  start_runs_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_start_write |=> s_running)
    else $error("start did not begin a calibration cycle");

  done_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_start_write |=> !done_q)
    else $error("done flag not cleared at start");

  finish_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    finish |=> (done_q && !o_cal_busy && comp_res_q == $past(i_comp_result)))
    else $error("finish did not set done and capture result");

  busy_mode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_cal_busy == (state_q == ST_RUN))
    else $error("busy flag disagrees with engine state");

  tick_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !act_clk_en_q |=> !o_cal_clk_tick)
    else $error("calibration tick while clock disabled");

  tick_spacing_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tick && !upd_q && act_div_q == 3'h1 && $stable(act_div_q) && act_clk_en_q
      |=> !tick ##1 (tick || !act_clk_en_q || $changed(act_div_q)))
    else $error("divider period wrong");

  clear_results_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    clear_res && !finish |=> (flags_q == 6'h00 && comp_res_q == 7'h00))
    else $error("clear pulse did not reset results");

  gain_select_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_q == ST_IDLE) |=> o_ch1_gain == $past(act_gain_q))
    else $error("programmed gain not used outside calibration");

  read_done_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_rd_en && i_addr == OFS_COMP_OFS |=> o_rd_valid && o_rdata[CALIB_DONE_FLAG_BIT] == $past(done_q))
    else $error("done flag readback wrong");

endmodule

//--- inc/cal_regs_pkg.sv
// How it works
// - bit 15 enables and reports internal resistor
// - bits 4:0 hold resistor value, reset 0x0A
// - bits 12:8 show calibrated resistor value
// - six read-only overflow and underflow result flags
// - bit 8 high then low clears results
// - bit 7 reads high while calibrating
// - bit 6 enables gain calibration circuitry
// - bits 5:4 select offset range, reset zero
// - calibration clock gated by bit 3
// - bits 2:0 set calibration clock divider
// - bits 14:8 show comparator offset result
// - bit 1 flags completed calibration cycle
// - writing bit 0 starts calibration cycle
// - update bit applies staged settings, self-clears
// - gain field governs only outside calibration
package cal_regs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [6:0] OFS_CH1_GAIN   = 7'h07;
  localparam logic [6:0] OFS_CH1_RSET   = 7'h0C;
  localparam logic [6:0] OFS_CAL_CONFIG = 7'h0D;
  localparam logic [6:0] OFS_COMP_OFS   = 7'h0E;
  localparam logic [6:0] OFS_UPDATE     = 7'h1D;
  localparam logic [6:0] OFS_PAT_STATE  = 7'h1E;
  // ==========================================================
  // field positions
  localparam int RSET_EN_BIT    = 15;
  localparam int RSET_CAL_LSB   = 8;
  localparam int RSET_LSB       = 0;
  localparam int COMP_OF_BIT    = 14;
  localparam int COMP_UF_BIT    = 13;
  localparam int RCAL_OF_BIT    = 12;
  localparam int RCAL_UF_BIT    = 11;
  localparam int GCAL_OF_BIT    = 10;
  localparam int GCAL_UF_BIT    = 9;
  localparam int CAL_RESET_BIT  = 8;
  localparam int CAL_MODE_BIT   = 7;
  localparam int CAL_MODE_EN_BIT= 6;
  localparam int RANGE_LSB      = 4;
  localparam int CLK_EN_BIT     = 3;
  localparam int CLK_DIV_LSB    = 0;
  localparam int COMP_CAL_LSB   = 8;
  localparam int CALIB_DONE_FLAG_BIT    = 1;
  localparam int START_BIT      = 0;
  localparam int UPDATE_BIT     = 0;
  localparam int GAIN_CAL_LSB   = 8;
  localparam int GAIN_LSB       = 0;
  // ==========================================================
  // field widths and reset values
  localparam int RSET_W  = 5;
  localparam int RANGE_W = 2;
  localparam int DIV_W   = 3;
  localparam int COMP_W  = 7;
  localparam int GAIN_W  = 7;
  localparam logic [4:0] RSET_RESET  = 5'h0A;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [2:0] DIV_RESET   = 3'h0;
  // calibration cycle length, in calibration clock ticks
  localparam int CAL_TICKS_DEFAULT = 16;
  // ==========================================================
  // calibration engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } cal_state_t;
endpackage

//--- test/cal_analog_model.sv
`timescale 1ns/100ps
// ==========================================================
// analog calibration circuit stand-in
module cal_analog_model (
  // run state seen from the register block
  input  wire logic       i_busy,
  // values the circuit settles to during a run
  input  wire logic [6:0] i_comp,
  input  wire logic [4:0] i_rset,
  input  wire logic [6:0] i_gain,
  input  wire logic [5:0] i_flags,
  // result lines into the register block
  output logic [6:0]      o_comp,
  output logic [4:0]      o_rset,
  output logic [6:0]      o_gain,
  output logic [5:0]      o_flags
);
  // outside a run the lines carry the inverse, so a stray capture shows up
  always_comb begin
    o_comp  = i_busy ? i_comp : ~i_comp;
    o_rset  = i_busy ? i_rset : ~i_rset;
    o_gain  = i_busy ? i_gain : ~i_gain;
    o_flags = i_busy ? i_flags : ~i_flags;
  end
endmodule

//--- test/tb_cal_regs.sv
`timescale 1ns/100ps
// ==========================================================
// register bank bench
module tb_cal_regs
  import cal_regs_pkg::*;
;
  localparam int TICKS = 3;          // short run keeps the bench quick
  logic i_clk, i_resetn, i_wr_en, i_rd_en, o_rd_valid, o_cal_clk_tick, o_cal_busy;
  logic o_gain_cal_en, o_rset_int_en;
  logic [6:0]  i_addr, o_ch1_gain, comp, gres, m_comp, m_gain;
  logic [15:0] i_wdata, o_rdata, w, w2, g;
  logic [4:0]  o_rset_code, rres, m_rset;
  logic [1:0]  o_offset_range;
  logic [5:0]  flags, m_flags;
  int          miscompares, total_checks, n, last, ticks;
  // ==========================================================
  // clock, device and far side
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  cal_regs #(.CAL_TICKS(TICKS)) i_cal_regs (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_wdata(i_wdata), .i_rd_en(i_rd_en), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .i_comp_result(m_comp), .i_comp_of(m_flags[5]), .i_comp_uf(m_flags[4]),
    .i_rset_result(m_rset), .i_rset_of(m_flags[3]), .i_rset_uf(m_flags[2]),
    .i_gain_result(m_gain), .i_gain_of(m_flags[1]), .i_gain_uf(m_flags[0]),
    .o_cal_clk_tick(o_cal_clk_tick), .o_cal_busy(o_cal_busy),
    .o_gain_cal_en(o_gain_cal_en), .o_offset_range(o_offset_range),
    .o_rset_int_en(o_rset_int_en), .o_rset_code(o_rset_code), .o_ch1_gain(o_ch1_gain));
  cal_analog_model i_cal_analog_model (
    .i_busy(o_cal_busy), .i_comp(comp), .i_rset(rres), .i_gain(gres), .i_flags(flags),
    .o_comp(m_comp), .o_rset(m_rset), .o_gain(m_gain), .o_flags(m_flags));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write strobe, released at the edge that takes it
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask
  // now=1 issues the read in the same step as the last write's release
  task automatic rd(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e,
                    input bit now);
    if (!now) @(posedge i_clk);
    i_addr  <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(16'(o_rd_valid), 16'h0001);
    chk(o_rdata & m, e);
  endtask
  task automatic upd();
    wr(OFS_UPDATE, 16'h0001);
    rd(OFS_UPDATE, 16'h0001, 16'h0001, 1'b1);
    rd(OFS_UPDATE, 16'h0001, 16'h0000, 1'b0);
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic reset_dut();
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(50 * 20000);
    miscompares++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    i_resetn = 1'b0;
    {i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
    {comp, rres, gres, flags} = '0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(74072));
    reset_dut();
    chk(16'(o_rset_code), 16'h000A);
    rd(OFS_CH1_RSET, 16'hFFFF, 16'h000A, 1'b0);
    rd(OFS_CAL_CONFIG, 16'hFFFF, 16'h0000, 1'b0);
    rd(OFS_COMP_OFS, 16'hFFFF, 16'h0000, 1'b0);
    // unmapped and out-of-scope places read zero, writes land nowhere
    wr(7'h05, 16'hFFFF);
    rd(7'h05, 16'hFFFF, 16'h0000, 1'b0);
    rd(OFS_PAT_STATE, 16'hFFFF, 16'h0000, 1'b0);
    for (int k = 0; k < 4; k++) begin
      w  = 16'($urandom);
      w2 = (16'($urandom) & 16'hFEFF) | 16'h0008;   // clock on, no clear pulse
      g  = 16'($urandom);
      if (k == 0) w2[2:0] = 3'h7;                   // slowest divider
      if (k == 1) w2[2:0] = 3'h0;                   // fastest divider
      if (k == 2) w2[2:0] = 3'h1;                   // every other cycle
      if (k == 0) w2[6] = 1'b1;                     // gain calibration on
      // read-only bits written with noise must stay clear
      wr(OFS_CH1_RSET, w);
      rd(OFS_CH1_RSET, 16'h1F1F, {11'h0, w[4:0]}, 1'b1);
      wr(OFS_CAL_CONFIG, w2);
      rd(OFS_CAL_CONFIG, 16'h7EFF, {9'h0, w2[6:0]}, 1'b1);
      wr(OFS_CH1_GAIN, g);
      upd();
      chk({o_rset_int_en, o_gain_cal_en, o_offset_range, o_rset_code, o_ch1_gain},
          {w[15], w2[6], w2[5:4], w[4:0], g[6:0]});
      comp  = 7'($urandom);
      rres  = 5'($urandom);
      gres  = 7'($urandom);
      flags = 6'($urandom);
      wr(OFS_COMP_OFS, 16'h0001);
      #1;
      chk(16'(o_cal_busy), 16'h0001);
      // tick spacing follows the divider while the clock is enabled
      n = 0;
      last = -1;
      while (o_cal_busy === 1'b1 && n < 2000) begin
        @(posedge i_clk);
        #1;
        n++;
        // while calibrating the gain output shows the stored (cleared) result
        if (o_cal_busy === 1'b1) chk(16'(o_ch1_gain), 16'h0000);
        if (o_cal_clk_tick === 1'b1) begin
          if (last >= 0) chk(16'(n - last), 16'(w2[2:0]) + 16'h1);
          last = n;
        end
      end
      if (n >= 2000) chk(16'h0BAD, 16'h0000);
      rd(OFS_COMP_OFS, 16'h7F02, {1'b0, comp, 8'h02}, 1'b0);
      rd(OFS_CAL_CONFIG, 16'h7EFF,
         {1'b0, flags[5:2], w2[6] ? flags[1:0] : 2'b00, 2'b00, w2[6:0]}, 1'b0);
      rd(OFS_CH1_RSET, 16'h9F1F, {w[15], 2'b00, rres, 3'b000, w[4:0]}, 1'b0);
      if (w2[6]) rd(OFS_CH1_GAIN, 16'h7F7F, {1'b0, gres, 1'b0, g[6:0]}, 1'b0);
      chk(16'(o_ch1_gain), 16'(g[6:0]));
      // clear pulse: high, then low
      wr(OFS_CAL_CONFIG, w2 | 16'h0100);
      wr(OFS_CAL_CONFIG, w2);
      rd(OFS_CAL_CONFIG, 16'h7E00, 16'h0000, 1'b0);
      rd(OFS_COMP_OFS, 16'h7F02, 16'h0000, 1'b0);
      rd(OFS_CH1_RSET, 16'h1F00, 16'h0000, 1'b0);
    end
    // clock gated off: the run starts but never ticks
    wr(OFS_CAL_CONFIG, 16'h0000);
    upd();
    wr(OFS_COMP_OFS, 16'h0001);
    ticks = 0;
    repeat (20) begin
      @(posedge i_clk);
      #1;
      if (o_cal_clk_tick === 1'b1) ticks++;
    end
    chk(16'(ticks), 16'h0000);
    rd(OFS_CAL_CONFIG, 16'h0080, 16'h0080, 1'b0);
    rd(OFS_COMP_OFS, 16'h0002, 16'h0000, 1'b0);
    // second reset in mid-run
    @(posedge i_clk);
    reset_dut();
    chk({11'(o_cal_busy), o_rset_code}, 16'h000A);
    finish_test();
  end
endmodule
